/* File: logic/tone_ctrl_pkg.sv */
/*
  Constants and types shared by the tone control sequencer and its follow detector.
  Assumes a single 10 MHz core clock.
*/
package tone_ctrl_pkg;
  // Core clock rate in Hz
  localparam int unsigned ClkHz = 10000000;
  // Nominal carrier, 22 kHz: integer division gives 454 cycles (45.4 us) a period
  localparam int unsigned ToneHz = 22000;
  localparam int unsigned TonePeriodCyc = ClkHz / ToneHz;
  localparam int unsigned ToneHalfCyc = TonePeriodCyc / 2;
  // Start delay 1.5 T and stop delay 2 T, counted in core cycles
  localparam int unsigned StartDelayCyc = (TonePeriodCyc * 3) / 2;
  localparam int unsigned StopDelayCyc = TonePeriodCyc * 2;
  // Accepted follow-input band, 20 to 24 kHz, as full-period cycle counts
  localparam int unsigned FollowMinHz = 20000;
  localparam int unsigned FollowMaxHz = 24000;
  localparam int unsigned PeriodMinCyc = ClkHz / FollowMaxHz;
  localparam int unsigned PeriodMaxCyc = (ClkHz + FollowMinHz - 1) / FollowMinHz;
  // Transmit-enable settle before a burst, 500 us
  localparam int unsigned TxSettleUs = 500;
  localparam int unsigned TxSettleCyc = TxSettleUs * (ClkHz / 1000000);
  // Receive detector holds its decision this long without a valid edge
  localparam int unsigned RxHoldCyc = StopDelayCyc;
  // Counter width covering every count above
  localparam int unsigned CntW = 13;
  typedef logic [CntW-1:0] cnt_t;
  // Register bit positions of the five-bit system register write field
  localparam int unsigned SysTxEnBit = 0;
  localparam int unsigned SysBurstBit = 1;
  localparam int unsigned SysVselBit = 2;
  localparam int unsigned SysLlcBit = 3;
  localparam int unsigned SysEnBit = 4;
  localparam int unsigned SysW = 5;
  // Output level codes
  typedef enum logic [1:0] {LvlOff, Lvl13v4, Lvl18v5, Lvl19v5} level_t;
  // Follow detector states
  typedef enum logic [1:0] {FolIdle, FolArm, FolOn} follow_state_t;

  // Check that a measured period lies within the accepted band
  function automatic logic periodOk(input cnt_t p);
    periodOk = (p >= cnt_t'(PeriodMinCyc)) && (p <= cnt_t'(PeriodMaxCyc));
  endfunction : periodOk
endpackage : tone_ctrl_pkg

/* File: logic/tone_period_if.sv */
/*
  Interface carrying period measurement results between the top and detectors.
  Assumes both sides run on core_clk.
*/
`timescale 1ns/10ps
interface tone_period_if;
  logic edgeSeen; // One-cycle pulse on each rising input edge
  logic periodValid; // Last completed period within band
  logic timedOut; // No edge for longer than the stop delay
  modport meas (output edgeSeen, output periodValid, output timedOut);
  modport user (input edgeSeen, input periodValid, input timedOut);
endinterface : tone_period_if

/* File: logic/tone_period_meter.sv */
/*
  Measures the period of a synchronised square wave and flags band and timeout.
  Assumes the input is already synchronised to core_clk.
*/
`timescale 1ns/10ps
module tone_period_meter
  import tone_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sigIn,
  tone_period_if.meas res
);
  logic prev_r, prev_nxt; // Previous sample for edge finding
  tone_ctrl_pkg::cnt_t cnt_r, cnt_nxt; // Cycles since last rising edge
  logic valid_r, valid_nxt; // Band decision of last period
  logic rise; // Rising edge this cycle

  // Next-state logic: count between rising edges, judge each period
  always_comb begin
    rise = sigIn && !prev_r;
    prev_nxt = sigIn;
    valid_nxt = valid_r;
    if (rise) begin
      cnt_nxt = '0;
      valid_nxt = periodOk(cnt_r + cnt_t'(1));
    end else if (cnt_r < cnt_t'(StopDelayCyc)) begin
      cnt_nxt = cnt_r + cnt_t'(1);
    end else begin
      // Saturate so a dead input stays timed out
      cnt_nxt = cnt_r;
      valid_nxt = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prev_r <= 1'b0;
      cnt_r <= cnt_t'(StopDelayCyc);
      valid_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign res.edgeSeen = rise;
  assign res.periodValid = valid_r;
  assign res.timedOut = (cnt_r >= cnt_t'(StopDelayCyc));
endmodule : tone_period_meter

/* File: logic/tone_gen_dish_control_sequencer.sv */
/*
  Tone path control: carrier generator, follow-input detector, receive
  detector, diagnostic flag, transmit-enable sequencing and level selection.
  Assumes all pins are asynchronous; all but the two fault pins are synchronised here; register bits
  arrive already latched by the serial interface on core_clk.
*/
// How it works
// - Modulation pin gates the internal carrier
// - Carrier 22 kHz, half period high
// - Follow tone starts 1.5 periods after edge
// - Follow tone stops 2 periods after input
// - Follow accepts 20-24 kHz input periods
// - Receive tone drives open-drain output low
// - Tone diagnostic flag readable by host
// - Transmit enable is pin OR bit
// - Burst allowed 500 us after enable
// - Level pin honoured only with select bit
// - Protection status and settings read back
// - Address pin picks one of two addresses
// - Five system register bits control functions
// - Diagnostic set when tone out of limits
`timescale 1ns/10ps
module tone_gen_dish_control_sequencer
  import tone_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic tone_modulation_in,
  input wire logic tone_follow_in,
  input wire logic tx_enable,
  input wire logic [tone_ctrl_pkg::SysW-1:0] system_register,
  input wire logic tone_receive_in,
  input wire logic level_select_pin,
  input wire logic addr_select_pin,
  input wire logic thermal_fault_in,
  input wire logic overload_fault_in,
  output logic tone_tx_output,
  output logic tone_detect_out_o,
  output logic tone_detect_out_oe_n,
  output logic tone_diag_flag,
  output logic tx_ready,
  output tone_ctrl_pkg::level_t regulator_output,
  output logic addr_select,
  output logic [tone_ctrl_pkg::SysW-1:0] settings_readback,
  output logic thermal_status,
  output logic overload_status
);
  // Two-stage synchronisers for every pin except the two fault inputs, which are registered once
  logic [5:0] sync1_r, sync2_r;
  logic modSync, folSync, txPinSync, rxSync, lvlSync, adrSync;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= {addr_select_pin, level_select_pin, tone_receive_in,
                  tx_enable, tone_follow_in, tone_modulation_in};
      sync2_r <= sync1_r;
    end
  end
  assign {adrSync, lvlSync, rxSync, txPinSync, folSync, modSync} = sync2_r;

  // Period meters for the follow input and the receive input
  tone_period_if folIf ();
  tone_period_if rxIf ();
  tone_period_meter folMeter (
    .core_clk(core_clk),
    .resetn(resetn),
    .sigIn(folSync),
    .res(folIf.meas)
  );
  tone_period_meter rxMeter (
    .core_clk(core_clk),
    .resetn(resetn),
    .sigIn(rxSync),
    .res(rxIf.meas)
  );

  // Carrier divider, settle timer, follow state and output registers
  cnt_t carCnt_r, carCnt_nxt; // Position inside one carrier period
  logic carrier_r, carrier_nxt; // Free-running carrier square wave
  cnt_t settle_r, settle_nxt; // Cycles since transmit enable rose
  logic ready_r, ready_nxt; // Transmit settle time elapsed
  follow_state_t fol_r, fol_nxt; // Follow detector state
  cnt_t folCnt_r, folCnt_nxt; // Start delay counter
  logic txOut_r, txOut_nxt;
  logic detOeN_r, detOeN_nxt; // Detector output enable, low while a tone is heard
  logic diag_r, diag_nxt;
  level_t lvl_r, lvl_nxt;
  logic adr_r, adr_nxt;
  logic [SysW-1:0] rb_r, rb_nxt;
  logic therm_r, therm_nxt, ovl_r, ovl_nxt;
  logic txEn, gateOn;

  // Next-state logic for the whole tone path
  always_comb begin
    txEn = txPinSync || system_register[SysTxEnBit];
    // Carrier divider: half period high, half low, nominal 22 kHz
    if (carCnt_r >= cnt_t'(TonePeriodCyc - 1)) begin
      carCnt_nxt = '0;
    end else begin
      carCnt_nxt = carCnt_r + cnt_t'(1);
    end
    carrier_nxt = (carCnt_nxt < cnt_t'(ToneHalfCyc));
    // Settle timer: counts while enabled, clears when dropped
    settle_nxt = settle_r;
    ready_nxt = ready_r;
    if (!txEn) begin
      settle_nxt = '0;
      ready_nxt = 1'b0;
    end else if (settle_r < cnt_t'(TxSettleCyc)) begin
      settle_nxt = settle_r + cnt_t'(1);
    end else begin
      ready_nxt = 1'b1;
    end
    // Follow detector: arm on first edge, start after 1.5 T, stop after 2 T silence
    fol_nxt = fol_r;
    folCnt_nxt = folCnt_r;
    case (fol_r)
      FolIdle: begin
        if (folIf.edgeSeen) begin
          fol_nxt = FolArm;
          folCnt_nxt = '0;
        end
      end
      FolArm: begin
        if (folIf.timedOut) begin
          fol_nxt = FolIdle; // Lone edge, no tone
        end else if (folCnt_r >= cnt_t'(StartDelayCyc - 1)) begin
          fol_nxt = FolOn;
        end else begin
          folCnt_nxt = folCnt_r + cnt_t'(1);
        end
      end
      FolOn: begin
        if (folIf.timedOut) begin
          fol_nxt = FolIdle;
        end
      end
      default: fol_nxt = FolIdle;
    endcase
    // Output gate: needs transmit enable, and the settle time for pin or bit bursts
    // An out-of-band follow wave raises the diagnostic flag but sends no tone
    gateOn = txEn && ((ready_r && (modSync || system_register[SysBurstBit]))
             || (fol_r == FolOn && folIf.periodValid));
    txOut_nxt = gateOn && carrier_r;
    // Receive decision: present while periods in band and not timed out
    detOeN_nxt = !(rxIf.periodValid && !rxIf.timedOut);
    // Diagnostic: follow detector in FolOn but follow input running outside the band
    diag_nxt = (fol_r == FolOn) && !folIf.periodValid;
    // Level selection, pin honoured only when the select bit is set
    if (!system_register[SysEnBit]) begin
      lvl_nxt = LvlOff;
    end else if (system_register[SysVselBit] && lvlSync) begin
      lvl_nxt = system_register[SysLlcBit] ? Lvl19v5 : Lvl18v5;
    end else begin
      lvl_nxt = Lvl13v4;
    end
    adr_nxt = adrSync;
    rb_nxt = system_register;
    therm_nxt = thermal_fault_in;
    ovl_nxt = overload_fault_in;
  end

  // Register stage
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      carCnt_r <= '0;
      carrier_r <= 1'b0;
      settle_r <= '0;
      ready_r <= 1'b0;
      fol_r <= FolIdle;
      folCnt_r <= '0;
      txOut_r <= 1'b0;
      detOeN_r <= 1'b1;
      diag_r <= 1'b0;
      lvl_r <= LvlOff;
      adr_r <= 1'b0;
      rb_r <= '0;
      therm_r <= 1'b0;
      ovl_r <= 1'b0;
    end else begin
      carCnt_r <= carCnt_nxt;
      carrier_r <= carrier_nxt;
      settle_r <= settle_nxt;
      ready_r <= ready_nxt;
      fol_r <= fol_nxt;
      folCnt_r <= folCnt_nxt;
      txOut_r <= txOut_nxt;
      detOeN_r <= detOeN_nxt;
      diag_r <= diag_nxt;
      lvl_r <= lvl_nxt;
      adr_r <= adr_nxt;
      rb_r <= rb_nxt;
      therm_r <= therm_nxt;
      ovl_r <= ovl_nxt;
    end
  end

  // Open drain: drive low only while a tone is present
  assign tone_tx_output = txOut_r;
  assign tone_detect_out_o = 1'b0;
  assign tone_detect_out_oe_n = detOeN_r;
  assign tone_diag_flag = diag_r;
  assign tx_ready = ready_r;
  assign regulator_output = lvl_r;
  assign addr_select = adr_r;
  assign settings_readback = rb_r;
  assign thermal_status = therm_r;
  assign overload_status = ovl_r;
endmodule : tone_gen_dish_control_sequencer

/* File: verification/tone_host_model.sv */
/* Host-side square wave source for the follow and receive pins.
   Assumes the bench supplies core_clk; the pin moves on the falling edge. */
`timescale 1ns/10ps
module tone_host_model (
  input wire logic core_clk,
  input wire logic run,
  input wire logic [9:0] halfCyc,
  output logic sq
);
  int cnt = 0; // Cycles into the current half period
  initial sq = 1'h0;
  // Pin rests low between bursts, like a grounded unused pin
  always @(negedge core_clk) begin
    if (!run || cnt >= halfCyc - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    sq <= run ? (cnt >= halfCyc - 1) ^ sq : 1'h0;
  end
endmodule : tone_host_model

/* File: verification/tone_gen_dish_control_sequencer_asserts.sv */
/* Port-level assertions for the tone sequencer.
   Bound to every sequencer instance; one core clock, sync reset. */
`timescale 1ns/10ps
module tone_gen_dish_control_sequencer_asserts
  import tone_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic tx_enable,
  input wire logic [tone_ctrl_pkg::SysW-1:0] system_register,
  input wire logic level_select_pin,
  input wire logic addr_select_pin,
  input wire logic tone_tx_output,
  input wire logic tone_detect_out_o,
  input wire logic tone_detect_out_oe_n,
  input wire logic tone_diag_flag,
  input wire logic tx_ready,
  input wire tone_ctrl_pkg::level_t regulator_output,
  input wire logic addr_select,
  input wire logic [tone_ctrl_pkg::SysW-1:0] settings_readback
);
  int enCnt_r, enCnt_nxt; // Cycles enable held; saturates so it never wraps
  int hiCnt_r, hiCnt_nxt; // Length of the current high run of the tone
  // Next counts
  always_comb begin
    enCnt_nxt = (tx_enable || system_register[SysTxEnBit]) ? enCnt_r + 1 : 0;
    if (enCnt_nxt > 6000) begin
      enCnt_nxt = 6000;
    end
    hiCnt_nxt = tone_tx_output ? hiCnt_r + 1 : 0;
  end
  // Register the counts
  always_ff @(posedge core_clk) begin
    enCnt_r <= resetn ? enCnt_nxt : 0;
    hiCnt_r <= resetn ? hiCnt_nxt : 0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_tx_off;
    (!tx_enable && !system_register[SysTxEnBit])[*6] |-> !tx_ready && !tone_tx_output;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("ready or tone without enable");
  property p_ready_late;
    $rose(tx_ready) |-> enCnt_r >= TxSettleCyc;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early");
  property p_ready_due;
    enCnt_r == TxSettleCyc + 8 |-> tx_ready;
  endproperty
  a_ready_due: assert property (p_ready_due) else $error("ready too late");
  property p_half;
    hiCnt_r <= ToneHalfCyc + 2;
  endproperty
  a_half: assert property (p_half) else $error("tone high half too long");
  property p_lvl_off;
    (!system_register[SysEnBit])[*3] |-> regulator_output == LvlOff;
  endproperty
  a_lvl_off: assert property (p_lvl_off) else $error("level not off");
  property p_lvl_low;
    (system_register[SysEnBit] && !system_register[SysVselBit])[*3]
      |-> regulator_output == Lvl13v4;
  endproperty
  a_lvl_low: assert property (p_lvl_low) else $error("pin honoured without select");
  property p_lvl_hi;
    (system_register[4:2] == 3'h7 && level_select_pin)[*5] |-> regulator_output == Lvl19v5;
  endproperty
  a_lvl_hi: assert property (p_lvl_hi) else $error("compensated high level wrong");
  property p_readback;
    $stable(system_register)[*2] |-> settings_readback == system_register;
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs");
  property p_addr;
    $stable(addr_select_pin)[*5] |-> addr_select == addr_select_pin;
  endproperty
  a_addr: assert property (p_addr) else $error("address select wrong");
  property p_drain;
    !tone_detect_out_oe_n |-> tone_detect_out_o == 1'h0;
  endproperty
  a_drain: assert property (p_drain) else $error("detector drives high");
  c_ready: cover property ($rose(tx_ready));
  c_detect: cover property ($fell(tone_detect_out_oe_n));
  c_diag: cover property ($rose(tone_diag_flag));
endmodule : tone_gen_dish_control_sequencer_asserts
bind tone_gen_dish_control_sequencer tone_gen_dish_control_sequencer_asserts u_asserts (
  .core_clk, .resetn, .tx_enable, .system_register, .level_select_pin, .addr_select_pin,
  .tone_tx_output, .tone_detect_out_o, .tone_detect_out_oe_n, .tone_diag_flag, .tx_ready,
  .regulator_output, .addr_select, .settings_readback);

/* File: verification/tone_gen_dish_control_sequencer_tb_top.sv */
/* Self-checking bench for the tone sequencer.
   Inputs move on the falling edge; two host models make the square waves. */
`timescale 1ns/10ps
module tone_gen_dish_control_sequencer_tb_top;
  import tone_ctrl_pkg::*;
  logic core_clk = 1'h0, resetn = 1'h0, tone_modulation_in = 1'h0, tx_enable = 1'h0;
  logic level_select_pin = 1'h0, addr_select_pin = 1'h0;
  logic thermal_fault_in = 1'h0, overload_fault_in = 1'h0;
  logic [SysW-1:0] system_register = 5'h00;
  logic fRun = 1'h0, rRun = 1'h0, tone_follow_in, tone_receive_in;
  logic [9:0] fHalf = 10'h0e3; // Nominal half period of the follow wave
  logic tone_tx_output, tone_detect_out_o, tone_detect_out_oe_n, tone_diag_flag, tx_ready;
  logic addr_select, thermal_status, overload_status;
  level_t regulator_output;
  logic [SysW-1:0] settings_readback;
  logic [4:0] obs; // Signals a bounded wait can watch
  logic [8:0] lv [6] = '{{2'h0, 5'h00, 2'h2}, {2'h1, 5'h10, 2'h3}, {2'h2, 5'h14, 2'h2},
    {2'h3, 5'h1c, 2'h3}, {2'h1, 5'h1c, 2'h0}, {2'h0, 5'h0c, 2'h2}};
  int bad_count = 0, num_checks = 0, n, q;
  assign obs = {tone_follow_in, tone_diag_flag, tx_ready, tone_detect_out_oe_n, tone_tx_output};
  initial forever #50 core_clk = !core_clk;
  tone_gen_dish_control_sequencer u_tone_gen_dish_control_sequencer (.core_clk, .resetn,
    .tone_modulation_in, .tone_follow_in, .tx_enable, .system_register, .tone_receive_in,
    .level_select_pin, .addr_select_pin, .thermal_fault_in, .overload_fault_in,
    .tone_tx_output, .tone_detect_out_o, .tone_detect_out_oe_n, .tone_diag_flag, .tx_ready,
    .regulator_output, .addr_select, .settings_readback, .thermal_status, .overload_status);
  tone_host_model u_follow (.core_clk, .run(fRun), .halfCyc(fHalf), .sq(tone_follow_in));
  tone_host_model u_receive (.core_clk, .run(rRun), .halfCyc(10'h0e3), .sq(tone_receive_in));
  // Print counts and the verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // Compare and count; lo above hi asks for an exact match; unknown bits always fail
  task automatic rng(input logic [31:0] got, input int lo, input int hi);
    num_checks++;
    if ($isunknown(got) || got < lo || got > (hi < lo ? lo : hi)) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, lo);
    end
  endtask : rng
  task automatic cyc(input int c);
    repeat (c) @(negedge core_clk);
  endtask : cyc
  // Bounded wait for obs[sel] to reach v; a hang ends the run
  task automatic waitSig(input int sel, input logic v, input int lim, output int t);
    t = 0;
    while (obs[sel] !== v) begin
      @(negedge core_clk);
      t++;
      if (t > lim) begin
        bad_count++;
        results();
      end
    end
  endtask : waitSig
  // Cycles until the tone has stayed low a full period, minus that period
  task automatic quiet(output int t);
    t = 0;
    q = 0;
    while (q < TonePeriodCyc) begin
      @(negedge core_clk);
      t++;
      q = tone_tx_output === 1'h0 ? q + 1 : 0;
      if (t > 4000) begin
        bad_count++;
        results();
      end
    end
    t = t - q;
  endtask : quiet
  initial begin
    cyc(4);
    resetn <= 1'h1;
    cyc(1);
    rng({tone_detect_out_oe_n, tx_ready, tone_tx_output, settings_readback}, 128, 0);
    foreach (lv[i]) begin
      system_register <= lv[i][6:2];
      level_select_pin <= lv[i][1];
      {addr_select_pin, thermal_fault_in, overload_fault_in} <= {3{lv[i][0]}};
      cyc(6);
      rng(regulator_output, lv[i][8:7], 0);
      rng(settings_readback, lv[i][6:2], 0);
      rng({addr_select, thermal_status, overload_status}, {3{lv[i][0]}}, 0);
    end
    system_register <= 5'h11;
    tone_modulation_in <= 1'h1;
    cyc(4000);
    rng(tone_tx_output, 0, 0);
    waitSig(2, 1'h1, 1100, n);
    waitSig(0, 1'h1, 600, n);
    // The gate opens at any carrier phase, so skip the first, possibly short, high run
    waitSig(0, 1'h0, 600, n);
    waitSig(0, 1'h1, 600, n);
    waitSig(0, 1'h0, 600, n);
    rng(n, ToneHalfCyc - 1, ToneHalfCyc + 1);
    waitSig(0, 1'h1, 600, n);
    rng(n, ToneHalfCyc - 1, ToneHalfCyc + 2);
    tone_modulation_in <= 1'h0;
    quiet(n);
    rng(n, 0, ToneHalfCyc + 4);
    system_register <= 5'h13;
    waitSig(0, 1'h1, 600, n);
    system_register <= 5'h11;
    cyc(2000);
    system_register <= 5'h10;
    cyc(8);
    rng(tx_ready, 0, 0);
    tx_enable <= 1'h1;
    waitSig(2, 1'h1, 5100, n);
    rng(n, 4995, 5010);
    fRun <= 1'h1;
    waitSig(0, 1'h1, 2000, n);
    rng(n, ToneHalfCyc + StartDelayCyc - 250, ToneHalfCyc + StartDelayCyc + 250);
    rng(tone_diag_flag, 0, 0);
    waitSig(4, 1'h1, 600, n);
    cyc(ToneHalfCyc);
    fRun <= 1'h0;
    quiet(n);
    rng(n, StopDelayCyc - 2 * ToneHalfCyc - 250, StopDelayCyc - ToneHalfCyc + 250);
    fHalf <= 10'h12c;
    fRun <= 1'h1;
    cyc(3000);
    rng(tone_diag_flag, 1, 0);
    quiet(n);
    rng(n, 0, 0);
    fRun <= 1'h0;
    rRun <= 1'h1;
    waitSig(1, 1'h0, 1500, n);
    rRun <= 1'h0;
    waitSig(1, 1'h1, 1500, n);
    rng(n, RxHoldCyc - ToneHalfCyc - 250, RxHoldCyc + 250);
    results();
  end
endmodule : tone_gen_dish_control_sequencer_tb_top
